//--- logic/bpd_dimmer.sv
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
module bpd_dimmer #(
  parameter int NUM_SINKS = bpd_pkg::NUM_SINKS
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [bpd_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic      [NUM_SINKS-1:0]       sink_out,
  output logic      [NUM_SINKS-1:0]       sink_oe,
  output logic                            backlight_boost_supply_en
);
  import bpd_pkg::*;

  // =====================================================
  // registers
  logic [7:0]        backlight_duty_level_r;
  logic [FREQ_W-1:0] backlight_freq_select_r;
  logic              sink_pwm_output_enable_r;
  logic              string_one_enable_r;
  logic              string_two_enable_r;
  logic              string_three_enable_r;
  logic [7:0]        duty_applied_r;
  logic [7:0]        slot_cnt_r;
  logic [ACC_W-1:0]  acc_r;
  logic              pwm_r;
  logic              ack_r;
  logic [31:0]       rdata_r;
  logic [NUM_SINKS-1:0] sink_oe_r;
  logic              boost_en_r;

  // =====================================================
  // bus decode: one wait state on every access
  wire              req        = avs_read | avs_write;
  wire [7:0]        word_idx   = avs_address[ADDR_W-1:2];
  wire              hit_string = (word_idx == IDX_STRING_CTRL);
  wire              hit_freq   = (word_idx == IDX_FREQ_CTRL);
  wire              hit_duty   = (word_idx == IDX_DUTY);
  wire              hit_status = (word_idx == IDX_STATUS);
  wire              wr_take    = avs_write & ack_r & avs_byteenable[0];
  wire [7:0]        wr_byte    = avs_writedata[7:0];

  wire [7:0] string_view = {string_three_enable_r, string_two_enable_r,
                            string_one_enable_r, 5'h00};
  wire [7:0] freq_view   = {1'b0, sink_pwm_output_enable_r, 1'b0, 2'h0,
                            backlight_freq_select_r};
  wire [31:0] status_view = {16'h0000, duty_applied_r, 7'h00, pwm_r};
  wire [31:0] rdata_nxt   = hit_string ? {24'h000000, string_view} :
                            hit_freq   ? {24'h000000, freq_view} :
                            hit_duty   ? {24'h000000, backlight_duty_level_r} :
                            hit_status ? status_view : 32'h00000000;

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // =====================================================
  // software-written fields; unmapped and reserved bits are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      backlight_duty_level_r   <= DUTY_RST;
      backlight_freq_select_r  <= FREQ_RST;
      sink_pwm_output_enable_r <= 1'b0;
      string_one_enable_r      <= 1'b0;
      string_two_enable_r      <= 1'b0;
      string_three_enable_r    <= 1'b0;
    end else if (wr_take) begin
      if (hit_duty) begin
        backlight_duty_level_r <= wr_byte;
      end
      if (hit_freq) begin
        backlight_freq_select_r  <= wr_byte[FREQ_LSB +: FREQ_W];
        sink_pwm_output_enable_r <= wr_byte[PWM_OUT_EN_BIT];
      end
      if (hit_string) begin
        string_one_enable_r   <= wr_byte[STRING_ONE_BIT];
        string_two_enable_r   <= wr_byte[STRING_TWO_BIT];
        string_three_enable_r <= wr_byte[STRING_THREE_BIT];
      end
    end
  end

  // =====================================================
  // slot time base: phase accumulator gives an exact average rate
  // of the reference times 2^code, so one 256-slot period equals
  // the reference divided by 256 >> code; reserved code runs as 110
  wire [FREQ_W-1:0] code_eff = (backlight_freq_select_r == FREQ_RESERVED) ?
                               FREQ_FASTEST : backlight_freq_select_r;
  wire [ACC_W-1:0]  step     = ACC_W'(REF_HZ) << code_eff;
  wire [ACC_W-1:0]  acc_sum  = acc_r + step;
  wire              slot_tick = (acc_sum >= ACC_W'(CLK_HZ));
  wire [ACC_W-1:0]  acc_nxt  = slot_tick ? acc_sum - ACC_W'(CLK_HZ) : acc_sum;
  wire              period_start = slot_tick & (slot_cnt_r == 8'hFF);

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // =====================================================
  // slot counter and compare; duty is latched only at the wrap so a
  // running period is never cut short or stretched
  always_ff @(posedge clk) begin
    if (srst) begin
      slot_cnt_r     <= 8'h00;
      duty_applied_r <= DUTY_RST;
    end else if (slot_tick) begin
      slot_cnt_r <= slot_cnt_r + 8'h01;
      if (period_start) begin
        duty_applied_r <= backlight_duty_level_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= (slot_cnt_r <= duty_applied_r);
    end
  end

  // =====================================================
  // sink drive: the fourth string has no enable bit of its own
  // and follows string three
  wire [NUM_SINKS-1:0] string_en;
  genvar g;
  generate
    for (g = 0; g < NUM_SINKS; g++) begin : g_sink
      if (g == 0) begin : g_one
        assign string_en[g] = string_one_enable_r;
      end else if (g == 1) begin : g_two
        assign string_en[g] = string_two_enable_r;
      end else begin : g_rest
        assign string_en[g] = string_three_enable_r;
      end
    end
  endgenerate

  wire [NUM_SINKS-1:0] pwm_all  = {NUM_SINKS{pwm_r}};
  wire [NUM_SINKS-1:0] sink_nxt = sink_pwm_output_enable_r ? pwm_all
                                                           : string_en & pwm_all;
  wire boost_nxt = ~sink_pwm_output_enable_r & (|string_en);

  always_ff @(posedge clk) begin
    if (srst) begin
      sink_oe_r  <= '0;
      boost_en_r <= 1'b0;
    end else begin
      sink_oe_r  <= sink_nxt;
      boost_en_r <= boost_nxt;
    end
  end

  // sinks only ever pull low; the pull-up or LED string sets the high level
  assign sink_out                  = '0;
  assign sink_oe                   = sink_oe_r;
  assign backlight_boost_supply_en = boost_en_r;

  // =====================================================
  // checks
  bus_wait_a: assert property (@(posedge clk) disable iff (srst)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("access not answered after one wait state");

  reset_val_a: assert property (@(posedge clk)
    srst |=> (backlight_duty_level_r == 8'h00 && backlight_freq_select_r == 3'h0))
    else $error("duty or frequency not cleared by reset");

  duty_hold_a: assert property (@(posedge clk) disable iff (srst)
    !period_start |=> $stable(duty_applied_r))
    else $error("applied duty changed inside a period");

  duty_load_a: assert property (@(posedge clk) disable iff (srst)
    period_start |=> duty_applied_r == $past(backlight_duty_level_r))
    else $error("new duty not applied at period start");

  tick_gap_a: assert property (@(posedge clk) disable iff (srst)
    slot_tick |=> !slot_tick [*8])
    else $error("slot ticks faster than the fastest code allows");

  slot_wrap_a: assert property (@(posedge clk) disable iff (srst)
    period_start |=> (slot_cnt_r == 8'h00) ##1 pwm_r)
    else $error("period did not start with the output on");

  full_on_a: assert property (@(posedge clk) disable iff (srst)
    (duty_applied_r == 8'hFF) [*2] |-> pwm_r)
    else $error("all-ones duty not fully on");

  pwm_mode_a: assert property (@(posedge clk) disable iff (srst)
    $past(sink_pwm_output_enable_r) |-> sink_oe == {NUM_SINKS{$past(pwm_r)}})
    else $error("pwm output mode does not follow the level");

  string_off_a: assert property (@(posedge clk) disable iff (srst)
    (!sink_pwm_output_enable_r && !string_one_enable_r) |=> !sink_oe[0])
    else $error("disabled string one still sinking");

  boost_use_a: assert property (@(posedge clk) disable iff (srst)
    sink_pwm_output_enable_r |=> !backlight_boost_supply_en)
    else $error("boost requested in pwm output mode");
endmodule
`default_nettype wire

//--- logic/bpd_pkg.sv
`default_nettype none
package bpd_pkg;
  // =====================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_STRING_CTRL = 8'h28;
  localparam logic [7:0] IDX_FREQ_CTRL   = 8'h29;
  localparam logic [7:0] IDX_DUTY        = 8'h2A;
  localparam logic [7:0] IDX_STATUS      = 8'h2B;
  localparam int         ADDR_W          = 10;
  // =====================================================
  // field positions
  localparam int STRING_ONE_BIT   = 5;
  localparam int STRING_TWO_BIT   = 6;
  localparam int STRING_THREE_BIT = 7;
  localparam int FREQ_LSB         = 0;
  localparam int FREQ_W           = 3;
  localparam int PWM_OUT_EN_BIT   = 6;
  localparam int STAT_LEVEL_BIT   = 0;
  localparam int STAT_DUTY_LSB    = 8;
  // =====================================================
  // reset values, plus the reserved and fastest frequency codes
  localparam logic [7:0]        DUTY_RST      = 8'h00;
  localparam logic [FREQ_W-1:0] FREQ_RST      = 3'h0;
  localparam logic [FREQ_W-1:0] FREQ_RESERVED = 3'h7;
  localparam logic [FREQ_W-1:0] FREQ_FASTEST  = 3'h6;
  // =====================================================
  // time base: slot rate is the reference times two to the code, with reserved code 7 run as 6
  localparam int CLK_HZ       = 25000000;
  localparam int REF_HZ       = 32768;
  localparam int ACC_W        = 26;
  localparam int SLOTS        = 256;
  localparam int NUM_SINKS    = 4;
  // least clocks between slot ticks at the fastest code
  localparam int MIN_TICK_GAP = CLK_HZ / (REF_HZ * 64);
endpackage
`default_nettype wire

//--- verif/bpd_led_load.sv
`default_nettype none
module bpd_led_load (
  input  wire logic        clk,
  input  wire logic [3:0]  sink_out,
  input  wire logic [3:0]  sink_oe,
  output logic      [3:0]  pin,
  output logic      [31:0] period_clks,
  output logic      [31:0] on_clks,
  output logic      [31:0] starts
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // pulled-up lines, a conducting sink pulls its line down
  assign pin = (sink_oe & sink_out) | ~sink_oe;
  // ==========================================
  // period and on-time of line one, measured from each turn-on edge
  logic        prev_r = 1'b1;
  logic [31:0] cnt_r  = 32'h0;
  logic [31:0] low_r  = 32'h0;
  logic [31:0] n_r    = 32'h0;
  assign starts = n_r;
  always_ff @(posedge clk) begin
    prev_r <= pin[0];
    if (prev_r && !pin[0]) begin
      period_clks <= cnt_r;
      on_clks     <= low_r;
      n_r         <= n_r + 32'h1;
      cnt_r       <= 32'h1;
      low_r       <= 32'h1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      low_r <= low_r + {31'h0, ~pin[0]};
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t: got %0h want %0h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bpd_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [9:0]  avs_address = 10'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, period_clks, on_clks, starts, rd, r;
  logic [3:0]  sink_out, sink_oe, pin;
  logic        avs_waitrequest, boost, all;
  logic [7:0]  da, db;
  logic [9:0]  ad[3] = '{10'h0A0, 10'h0A4, 10'h0A8};
  logic [31:0] mk[3] = '{32'hE0, 32'h47, 32'hFF};
  int          errors = 0, n_tests = 0, cyc = 0;
  bpd_dimmer bpd_dimmer_i (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sink_out(sink_out), .sink_oe(sink_oe),
    .backlight_boost_supply_en(boost));
  bpd_led_load bpd_led_load_i (.clk(clk), .sink_out(sink_out), .sink_oe(sink_oe),
    .pin(pin), .period_clks(period_clks), .on_clks(on_clks), .starts(starts));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // expectations: clocks spent in a number of slots
  function automatic real ex(int slots, logic [2:0] code);
    return real'(CLK_HZ) * slots / (real'(REF_HZ) * (2 ** (code == 3'h7 ? 6 : code)));
  endfunction
  // the phase accumulator jitters a slot edge by one clock
  function automatic logic near(logic [31:0] got, real e);
    return (real'(got) > e - 2.5) && (real'(got) < e + 2.5);
  endfunction
  // ==========================================
  // bus master
  task automatic ack;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be = 4'h1);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    ack();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [9:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    ack();
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wstart(int n);
    logic [31:0] s;
    s = starts;
    while (starts < s + n) @(posedge clk);
  endtask
  // duty only changes between measurements, far apart in time
  // the load is a pulled-up line, so short on-times are fine here; a host driving
  // real strings keeps the on-time per period above the LED minimum
  task automatic meas(logic [2:0] code, logic [7:0] d);
    wr(10'h0A8, {24'h0, d});
    wr(10'h0A4, {29'h0, code});
    wstart(3);
    `CHK(near(period_clks, ex(256, code)), 1'b1)
    `CHK(near(on_clks, ex(int'(d) + 1, code)), 1'b1)
    $display("test meas code %0d done", code);
  endtask
  initial begin
    void'($urandom(11));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // slot 0 with duty 0 is an on slot, so the status level bit reads one
    for (int i = 0; i < 4; i++) begin
      rdr(10'h0A0 + 10'(4 * i));
      `CHK(rd, (i == 3) ? 32'h1 : 32'h0)
    end
    `CHK({sink_oe, boost}, 5'h0)
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      wr(ad[i], r);
      rdr(ad[i]);
      `CHK(rd, r & mk[i])
    end
    wr(10'h0A8, 32'h5A, 4'h0);
    rdr(10'h0A8);
    `CHK(rd, r & 32'hFF)
    wr(10'h3FC, 32'hFF);
    rdr(10'h3FC);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 3; i++) wr(ad[i], 32'h0);
    repeat (4) @(posedge clk);
    `CHK(sink_oe, 4'h0)
    $display("test registers done");
    wr(10'h0A0, 32'h20);
    meas(3'h6, 8'h00);
    `CHK({boost, pin[3:1]}, 4'hF)
    meas(3'h6, 8'h7F);
    meas(3'h5, 8'($urandom % 255));
    da = 8'($urandom % 127);
    meas(3'h7, da);
    wstart(1);
    db = da + 8'h80;
    wr(10'h0A8, {24'h0, db});
    rdr(10'h0AC);
    `CHK(rd[15:8], da)
    wstart(2);
    `CHK(near(on_clks, ex(int'(db) + 1, 3'h7)), 1'b1)
    rdr(10'h0AC);
    `CHK(rd[15:8], db)
    wr(10'h0A8, 32'hFF);
    wstart(1);
    all = 1'b1;
    repeat (3100) begin
      @(posedge clk);
      all &= sink_oe[0];
    end
    `CHK(all, 1'b1)
    wr(10'h0A0, 32'h0);
    wr(10'h0A4, 32'h46);
    wr(10'h0A8, 32'h80);
    wstart(3);
    `CHK(boost, 1'b0)
    `CHK(near(on_clks, ex(129, 3'h6)), 1'b1)
    all = 1'b1;
    repeat (400) begin
      @(posedge clk);
      all &= (pin === {4{pin[0]}});
    end
    `CHK(all, 1'b1)
    wr(10'h0A4, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(sink_oe, 4'h0)
    $display("test sinks done");
    finish_test();
  end
endmodule
`default_nettype wire
